// file: rtl/cmgc_map.svh
// register offsets, field positions, reset values and timing counts for the gate controller
`ifndef CMGC_MAP_SVH
`define CMGC_MAP_SVH
`define CMGC_OFF_CTRL      5'h00
`define CMGC_OFF_KEYS      5'h04
`define CMGC_OFF_DELAY     5'h08
`define CMGC_OFF_STATUS    5'h0C
`define CMGC_OFF_RESULT    5'h10
`define CMGC_OFF_COUNT_HI  5'h14
`define CMGC_OFF_PHASE     5'h18
`define CMGC_CTRL_MODE_LO  0
`define CMGC_CTRL_MODE_HI  3
`define CMGC_CTRL_SLOPE_A  4
`define CMGC_CTRL_SLOPE_B  5
`define CMGC_CTRL_COMMON   6
`define CMGC_CTRL_DELAY_EN 7
`define CMGC_CTRL_HOLD     8
`define CMGC_CTRL_GPIB     9
`define CMGC_CTRL_RES_LO   12
`define CMGC_CTRL_RES_HI   15
`define CMGC_KEY_HOLD      0
`define CMGC_KEY_RESET     1
`define CMGC_KEY_RECALL    2
`define CMGC_CTRL_RESET    32'h0000_6000
`define CMGC_CLK_HZ        10000000
`define CMGC_DELAY_MIN_US  200
`define CMGC_DELAY_MAX_MS  800
`define CMGC_DELAY_DEF_MS  10
`define CMGC_BLINK_S       2
`define CMGC_REF_HZ        32'h0098_9680
`define CMGC_GATE_BASE_CYC 10000
`define CMGC_DELAY_MIN_CYC ((`CMGC_DELAY_MIN_US * (`CMGC_CLK_HZ / 1000000)))
`define CMGC_DELAY_MAX_CYC ((`CMGC_DELAY_MAX_MS * (`CMGC_CLK_HZ / 1000)))
`define CMGC_DELAY_DEF_CYC ((`CMGC_DELAY_DEF_MS * (`CMGC_CLK_HZ / 1000)))
`define CMGC_BLINK_CYC     ((`CMGC_BLINK_S * `CMGC_CLK_HZ))
`endif

// file: rtl/cmgc_pkg.sv
// types shared by the gate controller files
package cmgc_pkg;
  typedef enum logic [3:0] {
    cmgc_freq, cmgc_period, cmgc_time_interval, cmgc_gated_totalize,
    cmgc_manual_totalize, cmgc_phase, cmgc_ratio, cmgc_elapsed, cmgc_check
  } cmgc_mode_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [4:0]  adr;
    logic [31:0] dat;
  } cmgc_wb_req_t;
  typedef struct packed {
    logic        gate;
    logic        hold;
    logic        panel;
    logic        bus_leds;
  } cmgc_ind_t;
endpackage

// file: rtl/cmgc_edge.sv
// edge detector for one input channel with slope choice
`timescale 1ns/1ns
module cmgc_edge (
  input  wire logic clk,        // 10 MHz timebase
  input  wire logic rst_b,      // async reset, active low
  input  wire logic sig,        // conditioned channel level
  input  wire logic pos_slope,  // 1 selects rising edges
  output logic      sel_edge,   // edge of chosen polarity
  output logic      opp_edge    // edge of opposite polarity
);
  logic last;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last <= 1'b0;
    end else begin
      last <= sig;
    end
  end
  always_comb begin
    sel_edge = pos_slope ? (sig & ~last) : (~sig & last);
    opp_edge = pos_slope ? (~sig & last) : (sig & ~last);
  end
endmodule // cmgc_edge

// file: rtl/cmgc_delay.sv
// stop-event holdoff timer
`timescale 1ns/1ns
`include "cmgc_map.svh"
module cmgc_delay (
  input  wire logic        clk,    // 10 MHz timebase
  input  wire logic        rst_b,  // async reset, active low
  input  wire logic        start,  // pulse: start holdoff
  input  wire logic        enable, // holdoff in use
  input  wire logic [23:0] cycles, // holdoff length in cycles
  output logic             armed   // stop event may be taken
);
  logic [23:0] left;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 24'h0;
    end else if (start) begin
      left <= enable ? cycles : 24'h0;
    end else if (left != 24'h0) begin
      left <= left - 24'h1;
    end
  end
  assign armed = (left == 24'h0);
endmodule // cmgc_delay

// file: rtl/cmgc_gate.sv
// measurement gate controller for a universal counter, wishbone registers
// What this block does
// - gated totalize counts chosen-slope channel A edges
// - B selected edge opens, opposite B edge closes
// - manual totalize mode lights hold indicator
// - hold key toggles manual count; gate lit
// - manual total accumulates; reset clears after stop
// - elapsed time toggles, accumulates, reset clears after stop
// - gate indicator on exactly during measurement
// - single-shot hold measures once per reset
// - interval A start, B stop; common uses A
// - optional holdoff before stop arming
// - phase reported as positive A lead
// - self-check loads fixed reference value, shows 10 MHz
// - recall in check blinks panel LEDs 2 s
// - holdoff 200 us to 800 ms, default 10 ms
`timescale 1ns/1ns
`include "cmgc_map.svh"
module cmgc_gate (
  input  wire logic                 clk,        // 10 MHz timebase
  input  wire logic                 rst_b,      // async reset, active low
  input  wire cmgc_pkg::cmgc_wb_req_t wb_req,   // wishbone request group
  output logic [31:0]               wb_dat_o,   // wishbone read data
  output logic                      wb_ack_o,   // wishbone acknowledge
  input  wire logic                 chan_a,     // conditioned channel A
  input  wire logic                 chan_b,     // conditioned channel B
  input  wire logic                 key_hold,   // hold key pulse
  input  wire logic                 key_reset,  // reset key pulse
  input  wire logic                 key_recall, // recall key pulse
  output cmgc_pkg::cmgc_ind_t       ind         // panel indicators
);
  logic [31:0] ctrl;
  logic [23:0] delay_cyc;
  logic [31:0] count;
  logic [31:0] result;
  logic [31:0] phase_acc;
  logic [31:0] period_acc;
  logic [31:0] phase_res;
  logic [31:0] gate_cnt;
  logic        gate;
  logic        run;
  logic        pending;
  logic        done_hold;
  logic        led_test;
  logic        blink;
  logic [24:0] blink_cnt;
  logic        a_sel, a_opp, b_sel, b_opp, stop_armed, acc_write;
  logic        hold_p, reset_p, recall_p, stop_ev, open_ev;
  logic [31:0] gate_len;
  cmgc_pkg::cmgc_mode_t mode;

  assign mode = cmgc_pkg::cmgc_mode_t'(ctrl[`CMGC_CTRL_MODE_HI:`CMGC_CTRL_MODE_LO]);
  assign acc_write = wb_req.cyc & wb_req.stb & wb_req.we & ~wb_ack_o;

  cmgc_edge u_edge_a (
    .clk       (clk),
    .rst_b     (rst_b),
    .sig       (chan_a),
    .pos_slope (ctrl[`CMGC_CTRL_SLOPE_A]),
    .sel_edge  (a_sel),
    .opp_edge  (a_opp)
  );
  cmgc_edge u_edge_b (
    .clk       (clk),
    .rst_b     (rst_b),
    .sig       (ctrl[`CMGC_CTRL_COMMON] ? chan_a : chan_b),
    .pos_slope (ctrl[`CMGC_CTRL_SLOPE_B]),
    .sel_edge  (b_sel),
    .opp_edge  (b_opp)
  );
  cmgc_delay u_delay (
    .clk    (clk),
    .rst_b  (rst_b),
    .start  (open_ev),
    .enable (ctrl[`CMGC_CTRL_DELAY_EN]),
    .cycles (delay_cyc),
    .armed  (stop_armed)
  );

  // key pulses from the panel or from the key register
  always_comb begin
    hold_p   = key_hold;
    reset_p  = key_reset;
    recall_p = key_recall;
    if (acc_write && wb_req.adr == `CMGC_OFF_KEYS && wb_req.sel[0]) begin
      hold_p   = hold_p | wb_req.dat[`CMGC_KEY_HOLD];
      reset_p  = reset_p | wb_req.dat[`CMGC_KEY_RESET];
      recall_p = recall_p | wb_req.dat[`CMGC_KEY_RECALL];
    end
  end

  // gate length from resolution digits: 3 and 4 give 1 ms, each step x10
  always_comb begin
    case (ctrl[`CMGC_CTRL_RES_HI:`CMGC_CTRL_RES_LO])
      4'h5:    gate_len = 32'(`CMGC_GATE_BASE_CYC) * 32'hA;
      4'h6:    gate_len = 32'(`CMGC_GATE_BASE_CYC) * 32'h64;
      4'h7:    gate_len = 32'(`CMGC_GATE_BASE_CYC) * 32'h3E8;
      4'h8:    gate_len = 32'(`CMGC_GATE_BASE_CYC) * 32'h2710;
      default: gate_len = 32'(`CMGC_GATE_BASE_CYC);
    endcase
  end

  // open and close events per mode
  always_comb begin
    open_ev = 1'b0;
    stop_ev = 1'b0;
    case (mode)
      cmgc_pkg::cmgc_gated_totalize: begin
        open_ev = pending & b_sel;
        stop_ev = gate & stop_armed & b_opp;
      end
      cmgc_pkg::cmgc_time_interval: begin
        open_ev = pending & a_sel;
        stop_ev = gate & stop_armed & ~open_ev &
                  (ctrl[`CMGC_CTRL_COMMON] ? a_opp : b_sel);
      end
      cmgc_pkg::cmgc_manual_totalize, cmgc_pkg::cmgc_elapsed: begin
        open_ev = ~gate & run;
        stop_ev = gate & ~run;
      end
      cmgc_pkg::cmgc_phase: begin
        open_ev = pending & a_sel;
        stop_ev = gate & b_sel;
      end
      default: begin
        open_ev = pending & a_sel;
        stop_ev = gate & (gate_cnt >= gate_len) & a_sel;
      end
    endcase
  end

  // control register and holdoff store
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl      <= `CMGC_CTRL_RESET;
      delay_cyc <= 24'(`CMGC_DELAY_DEF_CYC);
    end else if (acc_write && wb_req.adr == `CMGC_OFF_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_req.sel[i]) ctrl[i*8 +: 8] <= wb_req.dat[i*8 +: 8];
      end
    end else if (acc_write && wb_req.adr == `CMGC_OFF_DELAY) begin
      if (wb_req.dat < 32'(`CMGC_DELAY_MIN_CYC)) begin
        delay_cyc <= 24'(`CMGC_DELAY_MIN_CYC);
      end else if (wb_req.dat > 32'(`CMGC_DELAY_MAX_CYC)) begin
        delay_cyc <= 24'(`CMGC_DELAY_MAX_CYC);
      end else begin
        delay_cyc <= wb_req.dat[23:0];
      end
    end
  end

  // start/stop state for manual modes and single-shot arming
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run       <= 1'b0;
      pending   <= 1'b1;
      done_hold <= 1'b0;
    end else if (mode == cmgc_pkg::cmgc_manual_totalize ||
                 mode == cmgc_pkg::cmgc_elapsed) begin
      pending <= 1'b0;
      if (hold_p) run <= ~run;
    end else begin
      run <= 1'b0;
      // a finishing measurement sets done_hold over a reset press in the same cycle, but the press still re-arms pending
      if (stop_ev) begin
        done_hold <= ctrl[`CMGC_CTRL_HOLD];
        pending   <= ~ctrl[`CMGC_CTRL_HOLD] | reset_p;
      end else if (reset_p) begin
        pending   <= 1'b1;
        done_hold <= 1'b0;
      end else if (open_ev) begin
        pending <= 1'b0;
      end
    end
  end

  // gate and counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gate     <= 1'b0;
      gate_cnt <= 32'h0;
      count    <= 32'h0;
    end else begin
      if (open_ev) begin
        gate     <= 1'b1;
        gate_cnt <= 32'h0;
        if (mode != cmgc_pkg::cmgc_manual_totalize && mode != cmgc_pkg::cmgc_elapsed) begin
          count <= 32'h0;
        end
      end else if (stop_ev) begin
        gate <= 1'b0;
      end else if (gate) begin
        gate_cnt <= gate_cnt + 32'h1;
        case (mode)
          cmgc_pkg::cmgc_gated_totalize, cmgc_pkg::cmgc_manual_totalize, cmgc_pkg::cmgc_ratio:
            if (a_sel) count <= count + 32'h1;
          default:
            count <= count + 32'h1;
        endcase
      end else if (reset_p && !run) begin
        count <= 32'h0;
      end
    end
  end

  // phase: A-to-B delay over cycles since the last A edge, always a positive lead
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_acc  <= 32'h0;
      period_acc <= 32'h0;
      phase_res  <= 32'h0;
    end else if (mode == cmgc_pkg::cmgc_phase) begin
      period_acc <= a_sel ? 32'h0 : period_acc + 32'h1;
      if (stop_ev) begin
        phase_acc <= count;
        phase_res <= period_acc;
      end
    end
  end

  // result latch; check mode shows the reference
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= 32'h0;
    end else if (mode == cmgc_pkg::cmgc_check) begin
      result <= `CMGC_REF_HZ;
    end else if (stop_ev || mode == cmgc_pkg::cmgc_manual_totalize ||
                 mode == cmgc_pkg::cmgc_elapsed) begin
      result <= count;
    end
  end

  // led test blink in check mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_test  <= 1'b0;
      blink     <= 1'b0;
      blink_cnt <= 25'h0;
    end else if (mode != cmgc_pkg::cmgc_check || (reset_p && !recall_p)) begin
      led_test  <= 1'b0;
      blink     <= 1'b0;
      blink_cnt <= 25'h0;
    end else begin
      // leds start lit on recall, then alternate
      if (recall_p && !led_test) begin
        led_test <= 1'b1;
        blink    <= 1'b1;
      end else if (led_test) begin
        if (blink_cnt == 25'(`CMGC_BLINK_CYC - 1)) begin
          blink_cnt <= 25'h0;
          blink     <= ~blink;
        end else begin
          blink_cnt <= blink_cnt + 25'h1;
        end
      end
    end
  end

  always_comb begin
    ind.gate     = gate;
    ind.hold     = ((mode == cmgc_pkg::cmgc_manual_totalize ||
                     mode == cmgc_pkg::cmgc_elapsed) & ~run & ~gate) |
                   (ctrl[`CMGC_CTRL_HOLD] & mode != cmgc_pkg::cmgc_manual_totalize &
                    mode != cmgc_pkg::cmgc_elapsed);
    ind.panel    = led_test & blink;
    ind.bus_leds = led_test & blink & ctrl[`CMGC_CTRL_GPIB];
  end

  // wishbone slave, one wait-free answer the cycle after the request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req.cyc & wb_req.stb & ~wb_ack_o;
      case (wb_req.adr)
        `CMGC_OFF_CTRL:     wb_dat_o <= ctrl;
        `CMGC_OFF_DELAY:    wb_dat_o <= {8'h0, delay_cyc};
        `CMGC_OFF_STATUS:   wb_dat_o <= {27'h0, done_hold, led_test, run, pending, gate};
        `CMGC_OFF_RESULT:   wb_dat_o <= result;
        `CMGC_OFF_COUNT_HI: wb_dat_o <= count;
        `CMGC_OFF_PHASE:    wb_dat_o <= phase_res == 32'h0 ? 32'h0 :
                                        (phase_acc * 32'h168) / phase_res;
        default:            wb_dat_o <= 32'h0;
      endcase
    end
  end
endmodule // cmgc_gate

// file: tb/cmgc_chk.sv
// port checker for the gate controller, bound to its top module
`timescale 1ns/1ns
module cmgc_chk (
  input wire logic                   clk,      // timebase
  input wire logic                   rst_b,    // reset, active low
  input wire cmgc_pkg::cmgc_wb_req_t wb_req,   // bus request
  input wire logic [31:0]            wb_dat_o, // read data
  input wire logic                   wb_ack_o, // acknowledge
  input wire logic                   chan_b,   // channel B
  input wire cmgc_pkg::cmgc_ind_t    ind       // indicators
);
  logic [31:0] ctrl_q;
  logic [3:0]  b_hist;
  wire         take = wb_req.cyc && wb_req.stb && !wb_ack_o;
  // shadow of the control word, written at the edge the slave takes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctrl_q <= 32'h0000_6000;
    else if (take && wb_req.we && wb_req.adr == 5'h00) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_req.sel[i]) ctrl_q[i*8 +: 8] <= wb_req.dat[i*8 +: 8];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) b_hist <= 4'h0;
    else b_hist <= {b_hist[2:0], chan_b};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    take;
  endsequence
  sequence s_gate_move;
    ctrl_q[3:0] == 4'h3 && $stable(ctrl_q) && $changed(ind.gate);
  endsequence
  chk_ack_latency: assert property (s_take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_unmapped_zero: assert property (wb_ack_o && !$past(wb_req.we)
    && $past(wb_req.adr) == 5'h1C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_manual_hold_on: assert property ($rose(ctrl_q[3:0] == 4'h4) |-> ind.hold)
    else $error("hold off on manual select");
  chk_manual_excl: assert property (ctrl_q[3:0] == 4'h4 && ind.gate |-> !ind.hold)
    else $error("hold lit while counting");
  chk_gate_b_edge: assert property (s_gate_move |-> b_hist != 4'h0 && b_hist != 4'hF)
    else $error("gate moved without B edge");
  chk_panel_check: assert property ($rose(ind.panel) |-> ctrl_q[3:0] == 4'h8)
    else $error("panel test outside check");
  chk_bus_option: assert property ($rose(ind.bus_leds) |-> ctrl_q[9])
    else $error("bus leds test without option");
endmodule // cmgc_chk
bind cmgc_gate cmgc_chk u_chk (.clk(clk), .rst_b(rst_b), .wb_req(wb_req),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_b(chan_b), .ind(ind));

// file: tb/cmgc_panel_src.sv
// model of the operator keys and the two measured signals
`timescale 1ns/1ns
module cmgc_panel_src (
  input  wire logic clk,        // timebase
  output logic      chan_a,     // channel A level
  output logic      chan_b,     // channel B level
  output logic      key_hold,   // hold key
  output logic      key_reset,  // reset key
  output logic      key_recall  // recall key
);
  initial {chan_a, chan_b, key_hold, key_reset, key_recall} = 5'h00;
  // pulses spaced so each edge is seen alone
  task automatic pulse_a(input int n);
    repeat (n) begin
      @(posedge clk) chan_a <= 1'b1;
      repeat (2) @(posedge clk);
      chan_a <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic set_b(input logic v);
    @(posedge clk) chan_b <= v;
    repeat (3) @(posedge clk);
  endtask
  // one-cycle key press
  task automatic press(input int k);
    @(posedge clk);
    if (k == 0) key_hold <= 1'b1;
    if (k == 1) key_reset <= 1'b1;
    if (k == 2) key_recall <= 1'b1;
    @(posedge clk) {key_hold, key_reset, key_recall} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
endmodule // cmgc_panel_src

// file: tb/tb_top.sv
// self-checking bench for the gate controller
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  cmgc_pkg::cmgc_wb_req_t req = '0;
  logic [31:0]            dat_o;
  logic                   ack_o;
  logic                   ca, cb, kh, kr, kc;
  cmgc_pkg::cmgc_ind_t    ind;
  int                     err_count = 0;
  int                     compares = 0;
  int                     cycles = 0;
  logic [31:0]            q;
  cmgc_gate u_dut (.clk(clk), .rst_b(rst_b), .wb_req(req), .wb_dat_o(dat_o),
    .wb_ack_o(ack_o), .chan_a(ca), .chan_b(cb), .key_hold(kh),
    .key_reset(kr), .key_recall(kc), .ind(ind));
  cmgc_panel_src u_src (.clk(clk), .chan_a(ca), .chan_b(cb), .key_hold(kh),
    .key_reset(kr), .key_recall(kc));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one classic cycle; held until ack is sampled high at a rising edge
  task automatic bus_sel(input logic w, input logic [4:0] a, input logic [31:0] d,
                         input logic [3:0] s);
    @(posedge clk) req <= {1'b1, 1'b1, w, s, a, d};
    do begin
      @(posedge clk);
    end while (ack_o !== 1'b1);
    q = dat_o;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    bus_sel(w, a, d, 4'hF);
  endtask
  task automatic t_reset();
    bus(0, 5'h00, 0);
    `CHK(q, 32'h0000_6000)
    bus(0, 5'h08, 0);
    `CHK(q, 32'h0001_86A0)
    bus(0, 5'h1C, 0);
    `CHK(q, 32'h0000_0000)
  endtask
  task automatic t_delay();
    logic [31:0] wv[3];
    logic [31:0] ev[3];
    wv = '{32'h1, 32'hFF_FFFF, 32'h3039};
    ev = '{32'h7D0, 32'h7A_1200, 32'h3039};
    foreach (wv[i]) begin
      bus(1, 5'h08, wv[i]);
      bus(0, 5'h08, 0);
      `CHK(q, ev[i])
    end
  endtask
  task automatic t_gated();
    bus(1, 5'h00, 32'h0000_0033);
    u_src.pulse_a(2);
    u_src.set_b(1'b1);
    u_src.pulse_a(5);
    `CHK(ind.gate, 1'b1)
    u_src.set_b(1'b0);
    u_src.pulse_a(3);
    `CHK(ind.gate, 1'b0)
    bus(0, 5'h10, 0);
    `CHK(q, 32'h5)
  endtask
  task automatic t_manual();
    bus(1, 5'h00, 32'h0000_0004);
    `CHK(ind.hold, 1'b1)
    u_src.press(1);
    u_src.press(0);
    u_src.pulse_a(5);
    `CHK(ind.gate, 1'b1)
    `CHK(ind.hold, 1'b0)
    bus(1, 5'h04, 32'h1);
    u_src.pulse_a(3);
    `CHK(ind.gate, 1'b0)
    u_src.press(0);
    u_src.pulse_a(2);
    u_src.press(0);
    bus(0, 5'h14, 0);
    `CHK(q, 32'h7)
    u_src.press(1);
    bus(0, 5'h14, 0);
    `CHK(q, 32'h0)
  endtask
  task automatic t_check();
    bus(1, 5'h00, 32'h0000_4208);
    repeat (25000) @(posedge clk);
    bus(0, 5'h10, 0);
    `CHK(q, 32'h0098_9680)
    u_src.press(2);
    `CHK(ind.panel, 1'b1)
    `CHK(ind.bus_leds, 1'b1)
    u_src.press(1);
    `CHK(ind.panel, 1'b0)
  endtask
  // elapsed time over two start/stop cycles, byte lanes of ctrl and keys
  task automatic t_lanes();
    bus_sel(1, 5'h00, 32'hFFFF_FF07, 4'h1);
    bus(0, 5'h00, 0);
    `CHK(q, 32'h0000_0007)
    `CHK(ind.hold, 1'b1)
    bus_sel(1, 5'h04, 32'h1, 4'h2);
    bus(0, 5'h0C, 0);
    `CHK(q, 32'h0)
    bus_sel(1, 5'h04, 32'h1, 4'h1);
    repeat (20) @(posedge clk);
    `CHK(ind.gate, 1'b1)
    `CHK(ind.hold, 1'b0)
    bus(1, 5'h04, 32'h1);
    bus(1, 5'h04, 32'h1);
    bus(1, 5'h04, 32'h1);
    bus(0, 5'h14, 0);
    `CHK(q, 32'h1A)
    bus(1, 5'h04, 32'h2);
    bus(0, 5'h14, 0);
    `CHK(q, 32'h0)
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_delay();
    t_gated();
    t_manual();
    t_lanes();
    t_check();
    final_report();
  end
endmodule // tb_top
